// *** cmpc_pkg.sv ***
// Package of constants for the comparator control logic
package cmpc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] INTST_ADDR  = 12'h004;
  localparam logic [11:0] INTMSK_ADDR = 12'h008;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int ENABLE_BIT = 7;
  localparam int REFSEL_BIT = 6;
  localparam int FLAG_BIT   = 5;
  localparam int IEN_BIT    = 4;
  localparam int RESULT_BIT = 3;
  localparam int PINEN_BIT  = 2;
  localparam int MODE_HI    = 1;
  localparam int MODE_LO    = 0;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [1:0] MODE_FALL0   = 2'h0;
  localparam logic [1:0] MODE_RISE    = 2'h1;
  localparam logic [1:0] MODE_FALL2   = 2'h2;
  localparam logic [1:0] MODE_BOTH    = 2'h3;

  // Interrupt status bits of the system-level event register
  localparam int EV_FLAG_BIT = 0;
  localparam int EV_ERR_BIT  = 1;
  localparam int EV_WIDTH    = 2;

endpackage

// *** cmpc_sync.sv ***
// Two-stage synchroniser for the analog comparator result
module cmpc_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } cmpc_sync_st_t;

  cmpc_sync_st_t state_reg;
  cmpc_sync_st_t state_next;

  // Shift the level through two flops
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = asyncIn;
    state_next.stage2 = state_reg.stage1;
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stage2;

endmodule

// *** cmpc_top.sv ***
// Comparator control logic with APB register access
// Operation
// [R1] Control bit 7 enables the comparator module when set.
// [R2] Control bit 6 picks the positive pin (0) or bandgap reference (1).
// [R3] Bit 5 flag is set on each selected compare event and stays set.
// [R4] Writing one to the flag clears it, writing zero leaves it.
// [R5] With bit 4 set the interrupt request is high while the flag is set.
// [R6] Reading bit 3 returns the present comparator result.
// [R7] The result bit is 0 after reset and reads 0 while disabled.
// [R8] With bit 2 set the result drives the result pin, else not. The code drives the pin only while bit 7 is also set.
// [R9] Mode bits 1:0 pick falling (00, 10), rising (01) or both (11).
// [R10] Logic keeps running in wait mode so its interrupt can wake the core.
// [R11] In the shallowest stop mode the enabled logic keeps full operation.
// [R12] After deep stop wake or reset all state is at reset values.
// [R13] In background debug the logic runs exactly as in normal run.
// [R14] The raw result passes two flops before edge detection.
module cmpc_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        comparatorRaw,
  output logic             analogEnable,
  output logic             referenceInputSelect,
  output logic             comparatorOutputPin,
  output logic             comparatorOutputPinOe,
  output logic             compareIrq,
  output logic             sysIrq
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    CMPC_IDLE   = 2'h0,
    CMPC_ACCESS = 2'h1,
    CMPC_DONE   = 2'h3
  } cmpc_bus_t;

  typedef struct packed {
    cmpc_bus_t                      busState;
    logic [7:0]                     ctrl;
    logic                           lastResult;
    logic [cmpc_pkg::EV_WIDTH-1:0]  evStatus;
    logic [cmpc_pkg::EV_WIDTH-1:0]  evMask;
    logic [31:0]                    rdata;
    logic                           ready;
    logic                           slvErr;
    logic                           pinOut;
    logic                           pinOe;
    logic                           irq;
    logic                           sirq;
  } cmpc_st_t;

  cmpc_st_t state_reg;
  cmpc_st_t state_next;

  logic resultSync;
  logic resultLive;
  logic riseEv;
  logic fallEv;
  logic compareEv;
  logic wrStrobe;
  logic rdStrobe;
  logic decodeHit;

  // ****************************************
  // Functions
  // ****************************************
  // Decide whether an edge matches the selected mode
  function automatic logic edgeMatch(input logic [1:0] mode,
                                     input logic       rise,
                                     input logic       fall);
    logic hit;
    hit = 1'b0;
    case (mode)
      cmpc_pkg::MODE_RISE: hit = rise;
      cmpc_pkg::MODE_BOTH: hit = rise | fall;
      default:             hit = fall;
    endcase
    return hit;
  endfunction

  // Known register addresses
  function automatic logic addrKnown(input logic [11:0] a);
    return (a == cmpc_pkg::CTRL_ADDR) || (a == cmpc_pkg::INTST_ADDR) ||
           (a == cmpc_pkg::INTMSK_ADDR);
  endfunction

  // ****************************************
  // Result path
  // ****************************************
  // Synchronise the asynchronous comparator result
  cmpc_sync u_sync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn (comparatorRaw),
    .syncOut (resultSync)
  );

  // Gate by enable and detect edges, see [R14] see [R1] see [R7]
  assign resultLive = resultSync & state_reg.ctrl[cmpc_pkg::ENABLE_BIT];
  assign riseEv     = resultLive & ~state_reg.lastResult;
  assign fallEv     = ~resultLive & state_reg.lastResult;
  // Event selection by mode, see [R9] see [R10] see [R11] see [R13]
  assign compareEv  = state_reg.ctrl[cmpc_pkg::ENABLE_BIT] &
                      edgeMatch(state_reg.ctrl[cmpc_pkg::MODE_HI:
                                               cmpc_pkg::MODE_LO],
                                riseEv, fallEv);

  // Bus strobes at the access phase
  assign wrStrobe  = psel & penable & pwrite &
                     (state_reg.busState == CMPC_ACCESS);
  assign rdStrobe  = psel & penable & ~pwrite &
                     (state_reg.busState == CMPC_ACCESS);
  assign decodeHit = addrKnown(paddr);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next            = state_reg;
    state_next.ready      = 1'b0;
    state_next.slvErr     = 1'b0;
    state_next.lastResult = resultLive;

    // Bus sequencing: answer one cycle into the access phase
    case (state_reg.busState)
      CMPC_IDLE: begin
        if (psel && !penable) begin
          state_next.busState = CMPC_ACCESS;
        end
      end
      CMPC_ACCESS: begin
        if (psel && penable) begin
          state_next.busState = CMPC_DONE;
          state_next.ready    = 1'b1;
          state_next.slvErr   = ~decodeHit;
        end
      end
      CMPC_DONE: begin
        state_next.busState = CMPC_IDLE;
      end
      default: begin
        state_next.busState = CMPC_IDLE;
      end
    endcase

    // Register writes, byte lane 0 only
    if (wrStrobe && pstrb[0]) begin
      if (paddr == cmpc_pkg::CTRL_ADDR) begin
        state_next.ctrl[cmpc_pkg::ENABLE_BIT] =
          pwdata[cmpc_pkg::ENABLE_BIT];                    // see [R1]
        state_next.ctrl[cmpc_pkg::REFSEL_BIT] =
          pwdata[cmpc_pkg::REFSEL_BIT];                    // see [R2]
        state_next.ctrl[cmpc_pkg::IEN_BIT] = pwdata[cmpc_pkg::IEN_BIT];
        state_next.ctrl[cmpc_pkg::PINEN_BIT] =
          pwdata[cmpc_pkg::PINEN_BIT];
        state_next.ctrl[cmpc_pkg::MODE_HI:cmpc_pkg::MODE_LO] =
          pwdata[cmpc_pkg::MODE_HI:cmpc_pkg::MODE_LO];
        // Write one clears the flag, see [R4]
        if (pwdata[cmpc_pkg::FLAG_BIT]) begin
          state_next.ctrl[cmpc_pkg::FLAG_BIT] = 1'b0;
        end
      end
      if (paddr == cmpc_pkg::INTST_ADDR) begin
        state_next.evStatus = state_reg.evStatus &
                              ~pwdata[cmpc_pkg::EV_WIDTH-1:0];
      end
      if (paddr == cmpc_pkg::INTMSK_ADDR) begin
        state_next.evMask = pwdata[cmpc_pkg::EV_WIDTH-1:0];
      end
    end

    // Unmapped access sets the error event
    if (wrStrobe || rdStrobe) begin
      if (!decodeHit) begin
        state_next.evStatus[cmpc_pkg::EV_ERR_BIT] = 1'b1;
      end
    end

    // Result bit always mirrors gated level, see [R6] see [R7]
    state_next.ctrl[cmpc_pkg::RESULT_BIT] = resultLive;

    // Event wins over a same-cycle clear, see [R3]
    if (compareEv) begin
      state_next.ctrl[cmpc_pkg::FLAG_BIT]  = 1'b1;
      state_next.evStatus[cmpc_pkg::EV_FLAG_BIT] = 1'b1;
    end

    // Read data capture
    state_next.rdata = '0;
    if (rdStrobe) begin
      case (paddr)
        cmpc_pkg::CTRL_ADDR:   state_next.rdata = {24'h000000,
                                                   state_reg.ctrl};
        cmpc_pkg::INTST_ADDR:  state_next.rdata = {30'h0,
                                                   state_reg.evStatus};
        cmpc_pkg::INTMSK_ADDR: state_next.rdata = {30'h0,
                                                   state_reg.evMask};
        default:               state_next.rdata = '0;
      endcase
    end

    // Pin drive, see [R8]
    state_next.pinOe  = state_next.ctrl[cmpc_pkg::PINEN_BIT] &
                        state_next.ctrl[cmpc_pkg::ENABLE_BIT];
    state_next.pinOut = state_next.pinOe & resultLive;

    // Interrupt outputs, see [R5]
    state_next.irq  = state_next.ctrl[cmpc_pkg::FLAG_BIT] &
                      state_next.ctrl[cmpc_pkg::IEN_BIT];
    state_next.sirq = |(state_next.evStatus & state_next.evMask);
  end

  // State register, full reset, see [R12]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg          <= '0;
      state_reg.busState <= CMPC_IDLE;
      state_reg.ctrl     <= cmpc_pkg::CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata                = state_reg.rdata;
  assign pready                = state_reg.ready;
  assign pslverr               = state_reg.slvErr;
  assign analogEnable          = state_reg.ctrl[cmpc_pkg::ENABLE_BIT];
  assign referenceInputSelect  = state_reg.ctrl[cmpc_pkg::REFSEL_BIT];
  assign comparatorOutputPin   = state_reg.pinOut;
  assign comparatorOutputPinOe = state_reg.pinOe;
  assign compareIrq            = state_reg.irq;
  assign sysIrq                = state_reg.sirq;

  // ****************************************
  // Assertions
  // ****************************************
  property p_flag_on_event;
    @(posedge clk) disable iff (!arst_n)
      compareEv |=> state_reg.ctrl[cmpc_pkg::FLAG_BIT];
  endproperty
  a_flag_on_event: assert property (p_flag_on_event) // see [R3]
    else $error("flag not set after event");

  property p_flag_w1c;
    @(posedge clk) disable iff (!arst_n)
      (wrStrobe && pstrb[0] && paddr == cmpc_pkg::CTRL_ADDR &&
       pwdata[cmpc_pkg::FLAG_BIT] && !compareEv)
      |=> !state_reg.ctrl[cmpc_pkg::FLAG_BIT];
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) // see [R4]
    else $error("flag not cleared by write one");

  property p_flag_sticky;
    @(posedge clk) disable iff (!arst_n)
      (state_reg.ctrl[cmpc_pkg::FLAG_BIT] && !wrStrobe)
      |=> state_reg.ctrl[cmpc_pkg::FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // see [R3]
    else $error("flag dropped without write");

  property p_irq;
    @(posedge clk) disable iff (!arst_n)
      compareIrq == (state_reg.ctrl[cmpc_pkg::FLAG_BIT] &
                     state_reg.ctrl[cmpc_pkg::IEN_BIT]);
  endproperty
  a_irq: assert property (p_irq) // see [R5]
    else $error("irq does not follow flag and enable");

  property p_result_off;
    @(posedge clk) disable iff (!arst_n)
      !analogEnable |=> !state_reg.ctrl[cmpc_pkg::RESULT_BIT];
  endproperty
  a_result_off: assert property (p_result_off) // see [R7]
    else $error("result bit set while disabled");

  property p_result_track;
    @(posedge clk) disable iff (!arst_n)
      (analogEnable && $stable(analogEnable))
      |-> state_reg.ctrl[cmpc_pkg::RESULT_BIT] == $past(resultSync);
  endproperty
  a_result_track: assert property (p_result_track) // see [R6]
    else $error("result bit does not follow comparator");

  property p_pin_off;
    @(posedge clk) disable iff (!arst_n)
      !state_reg.ctrl[cmpc_pkg::PINEN_BIT] |-> !comparatorOutputPinOe;
  endproperty
  a_pin_off: assert property (p_pin_off) // see [R8]
    else $error("pin driven while disabled");

  property p_sync_delay;
    @(posedge clk) disable iff (!arst_n)
      (analogEnable && riseEv) |-> $past(comparatorRaw, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // see [R14]
    else $error("rise not two flops after raw input");

  property p_rise_mode;
    @(posedge clk) disable iff (!arst_n)
      (state_reg.ctrl[1:0] == cmpc_pkg::MODE_RISE && fallEv) |-> !compareEv;
  endproperty
  a_rise_mode: assert property (p_rise_mode) // see [R9]
    else $error("falling edge counted in rise mode");

  property p_enable_gate;
    @(posedge clk) disable iff (!arst_n)
      !state_reg.ctrl[cmpc_pkg::ENABLE_BIT] |-> !compareEv;
  endproperty
  a_enable_gate: assert property (p_enable_gate) // see [R1]
    else $error("event counted while disabled");

  property p_fall_mode;
    @(posedge clk) disable iff (!arst_n)
      (fallEv && state_reg.ctrl[cmpc_pkg::ENABLE_BIT] &&
       state_reg.ctrl[1:0] != cmpc_pkg::MODE_RISE) |-> compareEv;
  endproperty
  a_fall_mode: assert property (p_fall_mode) // see [R9]
    else $error("falling edge missed in falling mode");

  property p_pin_track;
    @(posedge clk) disable iff (!arst_n)
      comparatorOutputPinOe
      |-> comparatorOutputPin == state_reg.ctrl[cmpc_pkg::RESULT_BIT];
  endproperty
  a_pin_track: assert property (p_pin_track) // see [R8]
    else $error("pin does not show comparator result");

  c_event:  cover property (@(posedge clk) disable iff (!arst_n) compareEv);
  c_irq:    cover property (@(posedge clk) disable iff (!arst_n)
                            $rose(compareIrq));
  c_both:   cover property (@(posedge clk) disable iff (!arst_n)
                            state_reg.ctrl[1:0] == cmpc_pkg::MODE_BOTH &&
                            fallEv);
  c_pin:    cover property (@(posedge clk) disable iff (!arst_n)
                            comparatorOutputPin);

endmodule

// *** cmpc_analog_model.sv ***
// Behavioural model of the analog comparator core behind the block
module cmpc_analog_model (
  input  wire logic enable,
  input  wire logic refSelect,
  input  wire logic pinLevel,
  input  wire logic bandgapLevel,
  output logic      rawOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unpowered core leaks the pin level, so gating must happen inside
  assign rawOut = enable ? (refSelect ? bandgapLevel : pinLevel)
                         : pinLevel;
endmodule

// *** cmpc_top_bench.sv ***
// Self-checking bench for the comparator control logic
module cmpc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd, r;
  logic [3:0]  pstrb;
  logic        pready, pslverr, raw, aEn, refSel, outPin, outPinOe;
  logic        cmpIrq, sysIrq, pinLevel, bgLevel, err, flagE, prevE;
  logic [7:0]  ctrlE;
  logic [1:0]  stE, mskE;
  int          error_cnt, n_tests, cycles;

  cmpc_top i_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparatorRaw(raw), .analogEnable(aEn),
    .referenceInputSelect(refSel), .comparatorOutputPin(outPin),
    .comparatorOutputPinOe(outPinOe), .compareIrq(cmpIrq),
    .sysIrq(sysIrq));
  cmpc_analog_model i_core (.enable(aEn), .refSelect(refSel),
    .pinLevel(pinLevel), .bandgapLevel(bgLevel), .rawOut(raw));

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, then an idle edge; only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Control write; the model keeps writable bits, clears flag on one
  task automatic wctrl(input logic [7:0] d);
    apb(1'b1, cmpc_pkg::CTRL_ADDR, {24'h0, d});
    ctrlE = d & 8'hd7;
    if (d[5]) flagE = 1'b0;
    prevE = ctrlE[7] & (ctrlE[6] ? bgLevel : pinLevel);
  endtask

  task automatic wst(input logic [1:0] d);
    apb(1'b1, cmpc_pkg::INTST_ADDR, {30'h0, d});
    stE &= ~d;
  endtask

  // New analog levels; the model flags edges of the kind selected
  task automatic drive(input logic p, input logic b);
    logic nr;
    logic hit;
    pinLevel <= p;
    bgLevel <= b;
    nr = ctrlE[7] & (ctrlE[6] ? b : p);
    hit = nr ? ctrlE[0] : (ctrlE[1:0] != 2'h1);
    if (ctrlE[7] && nr != prevE && hit) begin
      flagE = 1'b1;
      stE[0] = 1'b1;
    end
    prevE = nr;
    repeat (6) @(posedge clk);
  endtask

  task automatic verify();
    apb(1'b0, cmpc_pkg::CTRL_ADDR, 32'h0);
    check(rd, {24'h0, ctrlE[7:6], flagE, ctrlE[4],
               prevE, ctrlE[2:0]});
    check({aEn, refSel}, {ctrlE[7], ctrlE[6]});
    check(cmpIrq, flagE & ctrlE[4]);
    check({outPin, outPinOe},
          {prevE & ctrlE[2], ctrlE[2] & ctrlE[7]});
    apb(1'b0, cmpc_pkg::INTST_ADDR, 32'h0);
    check(rd, {30'h0, stE});
    check(sysIrq, |(stE & mskE));
  endtask

  task automatic end_of_test();
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    {pinLevel, bgLevel, flagE, prevE, ctrlE, stE, mskE} = '0;
    {error_cnt, n_tests, cycles} = '0;
    seed = 32'h42;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    verify();
    for (int m = 0; m < 32; m++) begin
      r = xs();
      drive(1'b0, 1'b0);
      wctrl({m % 8 != 7, r[6], 1'b1, r[4], 1'b0, r[2], 2'(m)});
      wst(2'h3);
      apb(1'b1, cmpc_pkg::INTMSK_ADDR, {30'h0, r[9:8]});
      mskE = r[9:8];
      for (int s = 0; s < 6; s++) begin
        r = xs();
        drive(r[0], r[1]);
        verify();
      end
      wctrl(ctrlE & 8'hdf);
      verify();
    end
    // Unmapped access is refused and flagged
    apb(1'b1, 12'h00c, 32'hff);
    check(err, 1'b1);
    stE[1] = 1'b1;
    apb(1'b0, 12'h00c, 32'h0);
    check(rd, 32'h0);
    verify();
    wst(2'h2);
    verify();
    // Reset in mid-run restores every reset value
    drive(1'b1, 1'b1);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    {flagE, prevE, ctrlE, stE, mskE} = '0;
    @(posedge clk);
    verify();
    end_of_test();
  end
endmodule
